// ### hw/pllc_defines.svh
// Constants for the PLL and reference clock configuration block.
// Assumes inclusion by its bare name from hw/ and tb/, with hw/ on the include path.
`ifndef PLLC_DEFINES_SVH
`define PLLC_DEFINES_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PLLC_ADDR_PLL_CFG  8'h00
`define PLLC_ADDR_STATUS   8'h04
`define PLLC_ADDR_RATIO    8'h08
`define PLLC_ADDR_TIMER    8'h0c
`define PLLC_ADDR_PORT_SEL 8'h10
`define PLLC_ADDR_BLK_BASE 8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define PLLC_IN_DIV_LSB   0
`define PLLC_FEEDBACK_LSB 8
`define PLLC_POST_DIV_LSB 24
`define PLLC_BLK_SRC_BIT  0
`define PLLC_BLK_DRV_BIT  1
`define PLLC_BLK_DIV_LSB  8
`define PLLC_STAT_BOOT_BIT 2
`define PLLC_RATIO_DEN_LSB 16

// ****************************************************************
// Strap settings: post divider / feedback / input divider
// ****************************************************************
`define PLLC_S00_POST 3'h1
`define PLLC_S00_FB   12'h07a
`define PLLC_S11_POST 3'h2
`define PLLC_S11_FB   12'h077
`define PLLC_S10_POST 3'h2
`define PLLC_S10_FB   12'h031
`define PLLC_S01_POST 3'h2
`define PLLC_S01_FB   12'h017
`define PLLC_S_IN_DIV 6'h00

// ****************************************************************
// Timing
// ****************************************************************
`define PLLC_MCLK_NS      50
`define PLLC_REF_TICK_NS  10
`define PLLC_BOOT_WAIT_NS 15000
`define PLLC_BOOT_CYCLES  ((`PLLC_BOOT_WAIT_NS + `PLLC_MCLK_NS - 1) / `PLLC_MCLK_NS)
`define PLLC_TICKS_PER_CLK (`PLLC_MCLK_NS / `PLLC_REF_TICK_NS)

`endif

// ### hw/pllc_pkg.sv
// Types shared by the PLL and reference clock configuration block.
// Assumes nothing of its surroundings.
`default_nettype none
package pllc_pkg;
   // Boot sequencing states, Gray coded along the path
   typedef enum logic [1:0] {
      PLLC_ST_STRAP = 2'b00,
      PLLC_ST_WAIT  = 2'b01,
      PLLC_ST_RUN   = 2'b11
   } pllc_state_t;
   // Clock block source choice
   typedef enum logic {
      PLLC_SRC_REF = 1'b0,
      PLLC_SRC_EXT = 1'b1
   } pllc_src_t;
endpackage
`default_nettype wire

// ### hw/pllc_top.sv
// PLL ratio configuration, reference timer, clock blocks and port clock selection.
// Assumes all inputs synchronous to mclk and straps static around reset release.
`include "pllc_defines.svh"
`default_nettype none
module pllc_top #(
   parameter int NUM_BLK = 4,
   parameter int NUM_PORT = 8,
   parameter int BOOT_CYCLES = `PLLC_BOOT_CYCLES
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Mode straps
   input wire logic ratio_strap_low,
   input wire logic ratio_strap_high,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // PLL settings presented to the analog PLL
   output logic [2:0] post_divider,
   output logic [11:0] pll_feedback,
   output logic [5:0] pll_in_div,
   output logic pll_settings_valid,
   // Boot release once the start-up interval has run
   output logic boot_go,
   // Reference timer in 10ns ticks
   output logic [31:0] ref_timer,
   // Clock block pins: input, output, enable (low drives)
   input wire logic [NUM_BLK-1:0] blk_pin_in,
   output logic [NUM_BLK-1:0] blk_pin_out,
   output logic [NUM_BLK-1:0] blk_pin_oe_n,
   // Clock seen by each port
   output logic [NUM_PORT-1:0] port_clk
);
   import pllc_pkg::*;

   localparam int SELW = $clog2(NUM_BLK);

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Denominator of the tile ratio: 2 * (R+1) * (OD+1)
   function automatic logic [10:0] ratio_den(input logic [5:0] r, input logic [2:0] od);
      logic [10:0] a;
      logic [10:0] b;
      a = {5'h00, r} + 11'h001;
      b = {8'h00, od} + 11'h001;
      ratio_den = 11'((a * b) << 1);
   endfunction

   // Exact byte address hit test, used for every register
   function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
      hit = (a == base);
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   pllc_state_t state_q;                        // Boot sequencing state
   logic [1:0] strap_q;                         // Straps caught at release
   logic sw_written_q;                          // Software has rewritten dividers
   logic [15:0] boot_cnt_q;                     // Start-up interval counter
   logic [2:0] post_q;                          // Post divider in force
   logic [11:0] fb_q;                           // Feedback value in force
   logic [5:0] indiv_q;                         // Input divider in force
   logic valid_q;                               // Settings loaded
   logic boot_q;                                // Boot released
   logic [12:0] num_q;                          // Ratio numerator F+1
   logic [10:0] den_q;                          // Ratio denominator
   logic [31:0] timer_q;                        // Reference timer
   logic [31:0] rdata_q;                        // Read data, one cycle late
   logic [NUM_BLK-1:0] blk_src_q;               // Block source: 1 = pin
   logic [NUM_BLK-1:0] blk_drv_q;               // Block drives its pin
   logic [7:0] blk_div_q [NUM_BLK];             // Reference divide count
   logic [7:0] blk_cnt_q [NUM_BLK];             // Divider running count
   logic [NUM_BLK-1:0] blk_gen_q;               // Generated block clocks
   logic [NUM_BLK-1:0] pin_out_q;               // Pin drive copy
   logic [NUM_BLK-1:0] pin_oe_n_q;              // Pin enable, low drives
   logic [SELW-1:0] port_sel_q [NUM_PORT];      // Block feeding each port
   logic [NUM_PORT-1:0] port_clk_q;             // Port clocks
   logic pll_wr;                                // Divider register write

   assign pll_wr = reg_wr && hit(reg_addr, `PLLC_ADDR_PLL_CFG);

   // ****************************************************************
   // Strap capture and boot sequencing
   // ****************************************************************
   // Catch the straps on the first enabled edge after release, then count
   // out the start-up interval; the longest interval is used so boot is
   // never earlier than the slowest oscillator case needs.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= PLLC_ST_STRAP;
         strap_q <= 2'h0;
         boot_cnt_q <= 16'h0000;
         boot_q <= 1'b0;
      end else if (ce) begin
         unique case (state_q)
            PLLC_ST_STRAP: begin
               strap_q <= {ratio_strap_high, ratio_strap_low};
               state_q <= PLLC_ST_WAIT;
            end
            PLLC_ST_WAIT: begin
               if (boot_cnt_q == 16'(BOOT_CYCLES - 1)) begin
                  boot_q <= 1'b1;
                  state_q <= PLLC_ST_RUN;
               end else begin
                  boot_cnt_q <= boot_cnt_q + 16'h0001;
               end
            end
            PLLC_ST_RUN: begin
               // Stay booted until the next reset
               boot_q <= 1'b1;
            end
            default: begin
               // Illegal code recovers through capture
               state_q <= PLLC_ST_STRAP;
            end
         endcase
      end
   end

   // ****************************************************************
   // PLL divider values
   // ****************************************************************
   // Straps set the dividers until software writes; a write in the capture
   // cycle wins so software is never overridden. Field widths bound each
   // value to its legal range; the VCO window is software's duty.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         post_q <= `PLLC_S00_POST;
         fb_q <= `PLLC_S00_FB;
         indiv_q <= `PLLC_S_IN_DIV;
         sw_written_q <= 1'b0;
         valid_q <= 1'b0;
      end else if (ce) begin
         if (pll_wr) begin
            post_q <= reg_wdata[`PLLC_POST_DIV_LSB +: 3];
            fb_q <= reg_wdata[`PLLC_FEEDBACK_LSB +: 12];
            indiv_q <= reg_wdata[`PLLC_IN_DIV_LSB +: 6];
            sw_written_q <= 1'b1;
            valid_q <= 1'b1;
         end else if (state_q == PLLC_ST_STRAP && !sw_written_q) begin
            valid_q <= 1'b1;
            indiv_q <= `PLLC_S_IN_DIV;
            unique case ({ratio_strap_high, ratio_strap_low})
               2'b00: begin
                  post_q <= `PLLC_S00_POST;
                  fb_q <= `PLLC_S00_FB;
               end
               2'b11: begin
                  post_q <= `PLLC_S11_POST;
                  fb_q <= `PLLC_S11_FB;
               end
               2'b10: begin
                  post_q <= `PLLC_S10_POST;
                  fb_q <= `PLLC_S10_FB;
               end
               2'b01: begin
                  post_q <= `PLLC_S01_POST;
                  fb_q <= `PLLC_S01_FB;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Tile ratio
   // ****************************************************************
   // Tile clock = oscillator * num / den, shown to software as two fields of one word
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         num_q <= 13'h0001;
         den_q <= 11'h002;
      end else if (ce) begin
         num_q <= {1'b0, fb_q} + 13'h0001;
         den_q <= ratio_den(indiv_q, post_q);
      end
   end

   // ****************************************************************
   // Reference timer
   // ****************************************************************
   // Counts reference ticks; several ticks pass per system clock, so the
   // timer steps by that many each cycle and stays true to 10ns.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         timer_q <= 32'h0000_0000;
      end else if (ce) begin
         timer_q <= timer_q + 32'(`PLLC_TICKS_PER_CLK);
      end
   end

   // ****************************************************************
   // Clock blocks
   // ****************************************************************
   // Configuration of each block; reset puts every block on the reference
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         blk_src_q <= '0;
         blk_drv_q <= '0;
         for (int i = 0; i < NUM_BLK; i++) begin
            blk_div_q[i] <= 8'h00;
         end
      end else if (ce && reg_wr) begin
         for (int i = 0; i < NUM_BLK; i++) begin
            if (hit(reg_addr, 8'(`PLLC_ADDR_BLK_BASE + 4 * i))) begin
               blk_src_q[i] <= reg_wdata[`PLLC_BLK_SRC_BIT];
               blk_drv_q[i] <= reg_wdata[`PLLC_BLK_DRV_BIT];
               blk_div_q[i] <= reg_wdata[`PLLC_BLK_DIV_LSB +: 8];
            end
         end
      end
   end

   // Generated clock: the pin level, or the reference divided down.
   // A divide count of n toggles every n+1 enabled mclk cycles.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         blk_gen_q <= '0;
         for (int i = 0; i < NUM_BLK; i++) begin
            blk_cnt_q[i] <= 8'h00;
         end
      end else if (ce) begin
         for (int i = 0; i < NUM_BLK; i++) begin
            if (pllc_src_t'(blk_src_q[i]) == PLLC_SRC_EXT) begin
               blk_gen_q[i] <= blk_pin_in[i];
               blk_cnt_q[i] <= 8'h00;
            end else if (blk_cnt_q[i] >= blk_div_q[i]) begin
               blk_gen_q[i] <= ~blk_gen_q[i];
               blk_cnt_q[i] <= 8'h00;
            end else begin
               blk_cnt_q[i] <= blk_cnt_q[i] + 8'h01;
            end
         end
      end
   end

   // Drive a block's clock onto its pin when asked
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_out_q <= '0;
         pin_oe_n_q <= '1;
      end else if (ce) begin
         pin_out_q <= blk_gen_q;
         pin_oe_n_q <= ~blk_drv_q;
      end
   end

   // ****************************************************************
   // Port attachment
   // ****************************************************************
   // Which block clocks each port; reset attaches all to block 0
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int p = 0; p < NUM_PORT; p++) begin
            port_sel_q[p] <= '0;
         end
      end else if (ce && reg_wr && hit(reg_addr, `PLLC_ADDR_PORT_SEL)) begin
         for (int p = 0; p < NUM_PORT; p++) begin
            port_sel_q[p] <= reg_wdata[4 * p +: SELW];
         end
      end
   end

   // Port clocks follow their block one cycle later
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         port_clk_q <= '0;
      end else if (ce) begin
         for (int p = 0; p < NUM_PORT; p++) begin
            port_clk_q[p] <= blk_gen_q[port_sel_q[p]];
         end
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   // Read data stands the cycle after the strobe only; unmapped reads 0
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         rdata_q <= 32'h0000_0000;
         if (reg_rd) begin
            if (hit(reg_addr, `PLLC_ADDR_PLL_CFG)) begin
               rdata_q[`PLLC_POST_DIV_LSB +: 3] <= post_q;
               rdata_q[`PLLC_FEEDBACK_LSB +: 12] <= fb_q;
               rdata_q[`PLLC_IN_DIV_LSB +: 6] <= indiv_q;
            end
            if (hit(reg_addr, `PLLC_ADDR_STATUS)) begin
               rdata_q[1:0] <= strap_q;
               rdata_q[`PLLC_STAT_BOOT_BIT] <= boot_q;
               rdata_q[3] <= sw_written_q;
            end
            if (hit(reg_addr, `PLLC_ADDR_RATIO)) begin
               rdata_q[12:0] <= num_q;
               rdata_q[`PLLC_RATIO_DEN_LSB +: 11] <= den_q;
            end
            if (hit(reg_addr, `PLLC_ADDR_TIMER)) begin
               rdata_q <= timer_q;
            end
            if (hit(reg_addr, `PLLC_ADDR_PORT_SEL)) begin
               for (int p = 0; p < NUM_PORT; p++) begin
                  rdata_q[4 * p +: SELW] <= port_sel_q[p];
               end
            end
            for (int i = 0; i < NUM_BLK; i++) begin
               if (hit(reg_addr, 8'(`PLLC_ADDR_BLK_BASE + 4 * i))) begin
                  rdata_q[`PLLC_BLK_SRC_BIT] <= blk_src_q[i];
                  rdata_q[`PLLC_BLK_DRV_BIT] <= blk_drv_q[i];
                  rdata_q[`PLLC_BLK_DIV_LSB +: 8] <= blk_div_q[i];
               end
            end
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   assign post_divider = post_q;
   assign pll_feedback = fb_q;
   assign pll_in_div = indiv_q;
   assign pll_settings_valid = valid_q;
   assign boot_go = boot_q;
   assign ref_timer = timer_q;
   assign reg_rdata = rdata_q;
   assign blk_pin_out = pin_out_q;
   assign blk_pin_oe_n = pin_oe_n_q;
   assign port_clk = port_clk_q;

endmodule
`default_nettype wire

// ### tb/pllc_top_assertions.sv
// Concurrent checks on the PLL configuration block, bound to its top module.
// Assumes a single mclk domain and straps held steady through reset release.
`include "pllc_defines.svh"
`default_nettype none
module pllc_top_chk #(
   parameter int BOOT_CYCLES = 300
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic ratio_strap_low,
   input wire logic ratio_strap_high,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [2:0] post_divider,
   input wire logic [11:0] pll_feedback,
   input wire logic [5:0] pll_in_div,
   input wire logic pll_settings_valid,
   input wire logic boot_go,
   input wire logic [31:0] ref_timer
);
   // ****************************************************************
   // Helper logic
   // ****************************************************************
   // Enabled edges since release; saturates so long runs never wrap
   logic [31:0] edges_q;
   // Settings packed the way software reads them back
   logic [31:0] cfg_word;
   // Settings write taken at this edge
   logic cfg_wr;
   assign cfg_word = {5'h0, post_divider, 4'h0, pll_feedback, 2'h0, pll_in_div};
   assign cfg_wr = ce && reg_wr && (reg_addr == `PLLC_ADDR_PLL_CFG);
   // Count enabled edges after reset release
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         edges_q <= 32'h0;
      end else if (ce && (edges_q <= BOOT_CYCLES)) begin
         edges_q <= edges_q + 32'h1;
      end
   end
   // Strap code to settings word: post divider, feedback, input divider 0
   function automatic logic [31:0] strap_word(input logic [1:0] code);
      case (code)
         2'b00: strap_word = 32'h01007a00;
         2'b11: strap_word = 32'h02007700;
         2'b10: strap_word = 32'h02003100;
         default: strap_word = 32'h02001700;
      endcase
   endfunction
   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   strap_load_a: assert property (edges_q == 32'h1 && !$past(cfg_wr) |->
      pll_settings_valid && cfg_word == strap_word({ratio_strap_high, ratio_strap_low}))
      else $error("Strap settings missing after capture");
   settings_hold_a: assert property (pll_settings_valid && !cfg_wr |=>
      $stable(cfg_word) && pll_settings_valid)
      else $error("Settings changed without a write");
   cfg_write_a: assert property (cfg_wr |=> post_divider == $past(reg_wdata[26:24])
      && pll_feedback == $past(reg_wdata[19:8]) && pll_in_div == $past(reg_wdata[5:0]))
      else $error("Settings write not applied");
   cfg_read_a: assert property (ce && reg_rd && reg_addr == `PLLC_ADDR_PLL_CFG |=>
      reg_rdata == $past(cfg_word))
      else $error("Settings read back wrong");
   rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
      else $error("Read data not zero outside a read");
   unmapped_read_a: assert property (ce && reg_rd && reg_addr[7:4] > 4'h2 |=>
      reg_rdata == 32'h0)
      else $error("Unmapped read not zero");
   timer_step_a: assert property (ce |=> ref_timer == $past(ref_timer) + 32'h5)
      else $error("Timer did not advance by five ticks");
   timer_freeze_a: assert property (!ce |=> $stable(ref_timer) && $stable(cfg_word))
      else $error("State moved while disabled");
   boot_time_a: assert property (boot_go == (edges_q > BOOT_CYCLES))
      else $error("Boot release at wrong edge");
endmodule
bind pllc_top pllc_top_chk #(.BOOT_CYCLES(BOOT_CYCLES)) chk_u (.mclk(mclk), .rstn(rstn),
   .ce(ce), .ratio_strap_low(ratio_strap_low), .ratio_strap_high(ratio_strap_high),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .post_divider(post_divider), .pll_feedback(pll_feedback),
   .pll_in_div(pll_in_div), .pll_settings_valid(pll_settings_valid), .boot_go(boot_go),
   .ref_timer(ref_timer));
`default_nettype wire

// ### tb/pllc_osc_model.sv
// Board-side model: mode straps and an external clock on clock block pin 1.
// Assumes the bench picks the strap code before it asserts reset.
`default_nettype none
module pllc_osc_model (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [1:0] strap_sel,
   input wire logic ext_run,
   output logic ratio_strap_low,
   output logic ratio_strap_high,
   output logic [3:0] blk_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin clock divider; the pin rests low while the clock is stopped
   logic [1:0] div_q = 2'h0;
   // straps held static
   // Straps follow the chosen code only in reset, so they never move after release
   // A latch runs at time zero, so the straps never start out unknown
   always_latch begin
      if (!rstn) begin
         {ratio_strap_high, ratio_strap_low} <= strap_sel;
      end
   end
   // One pin level per two mclk cycles, launched just after the edge
   always @(posedge mclk) begin
      div_q <= ext_run ? div_q + 2'h1 : 2'h0;
   end
   assign blk_pin_in = {2'b00, div_q[1], 1'b0};
endmodule
`default_nettype wire

// ### tb/pllc_top_tb_top.sv
// Self-checking bench for the PLL configuration block.
// Assumes the board model and the bound checker stand beside the design.
`include "pllc_defines.svh"
`default_nettype none
module pllc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Short boot count keeps four resets cheap
   localparam int BOOT = 4;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic ratio_strap_low, ratio_strap_high;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, ref_timer, cfg_now, d, t;
   logic [2:0] post_divider;
   logic [11:0] pll_feedback;
   logic [5:0] pll_in_div;
   logic pll_settings_valid, boot_go;
   logic [3:0] blk_pin_in, blk_pin_out, blk_pin_oe_n;
   logic [7:0] port_clk;
   logic [1:0] strap_sel = 2'b00;
   logic [1:0] p;
   logic ext_run = 1'b0;
   int errors = 0;
   int checks_done = 0;
   int n;
   // Strap code, settings word, ratio register
   typedef struct packed {
      logic [1:0] code;
      logic [31:0] cfg;
      logic [31:0] ratio;
   } pllc_row_t;
   pllc_row_t rows [4] = '{'{2'b00, 32'h01007a00, 32'h0004007b},
      '{2'b11, 32'h02007700, 32'h00060078}, '{2'b10, 32'h02003100, 32'h00060032},
      '{2'b01, 32'h02001700, 32'h00060018}};
   assign cfg_now = {5'h0, post_divider, 4'h0, pll_feedback, 2'h0, pll_in_div};
   // Free-running 20 MHz clock
   always #25 mclk = ~mclk;
   pllc_top #(.BOOT_CYCLES(BOOT)) dut_u (.mclk(mclk), .rstn(rstn), .ce(ce),
      .ratio_strap_low(ratio_strap_low), .ratio_strap_high(ratio_strap_high),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .post_divider(post_divider), .pll_feedback(pll_feedback),
      .pll_in_div(pll_in_div), .pll_settings_valid(pll_settings_valid),
      .boot_go(boot_go), .ref_timer(ref_timer), .blk_pin_in(blk_pin_in),
      .blk_pin_out(blk_pin_out), .blk_pin_oe_n(blk_pin_oe_n), .port_clk(port_clk));
   pllc_osc_model osc_u (.mclk(mclk), .rstn(rstn), .strap_sel(strap_sel),
      .ext_run(ext_run), .ratio_strap_low(ratio_strap_low),
      .ratio_strap_high(ratio_strap_high), .blk_pin_in(blk_pin_in));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe, so it is taken at that edge
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      v = reg_rdata;
   endtask
   task automatic wrap_up();
      if (errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      // Every strap code through a full reset and boot
      for (int i = 0; i < 4; i++) begin
         strap_sel <= rows[i].code;
         @(posedge mclk);
         rstn <= 1'b0;
         repeat (2) @(posedge mclk);
         rstn <= 1'b1;
         // Bounded wait for boot release, checking capture on the way
         for (n = 1; n <= 40; n++) begin
            @(posedge mclk);
            if (n == 2) begin
               chk("strap settings", rows[i].cfg, cfg_now);
               chk("settings valid", 32'h1, {31'h0, pll_settings_valid});
            end
            if (boot_go === 1'b1) begin
               break;
            end
         end
         if (n > 40) begin
            errors++;
            wrap_up();
         end
         chk("boot edges", BOOT + 2, n);
         rd(`PLLC_ADDR_STATUS, d);
         chk("status", {28'h0, 2'b01, rows[i].code}, d);
         rd(`PLLC_ADDR_RATIO, d);
         chk("ratio", rows[i].ratio, d);
         rd(`PLLC_ADDR_PLL_CFG, d);
         chk("settings read back", rows[i].cfg, d);
      end
      // Reset attachment of ports to a reference-driven block 0
      rd(`PLLC_ADDR_PORT_SEL, d);
      chk("port select", 32'h0, d);
      rd(`PLLC_ADDR_BLK_BASE, d);
      chk("block 0 source", 32'h0, {31'h0, d[0]});
      // Reference divided by six: ten changes in thirty edges
      wr(`PLLC_ADDR_BLK_BASE, 32'h00000200);
      repeat (4) @(posedge mclk);
      n = 0;
      p[0] = port_clk[2];
      repeat (30) begin
         @(posedge mclk);
         n += (port_clk[2] !== p[0]);
         p[0] = port_clk[2];
      end
      chk("ref toggles", 32'd10, n);
      // Block 1 from its pin, driven out, port 0 moved onto it
      ext_run <= 1'b1;
      wr(`PLLC_ADDR_BLK_BASE + 8'h04, 32'h00000003);
      wr(`PLLC_ADDR_PORT_SEL, 32'h00000001);
      repeat (3) @(posedge mclk);
      chk("pin enables", 32'hd, {28'h0, blk_pin_oe_n});
      p = 2'b00;
      for (int k = 0; k < 12; k++) begin
         @(posedge mclk);
         if (k >= 2) begin
            chk("port 0 clock", p[1], port_clk[0]);
            chk("pin 1 out", p[1], blk_pin_out[1]);
         end
         p = {p[0], blk_pin_in[1]};
      end
      ext_run <= 1'b0;
      // Software settings inside the legal ranges and VCO window
      wr(`PLLC_ADDR_PLL_CFG, 32'h0300a501);
      @(posedge mclk);
      chk("new settings", 32'h0300a501, cfg_now);
      rd(`PLLC_ADDR_PLL_CFG, d);
      chk("settings read", 32'h0300a501, d);
      // Read-only and unmapped places ignore writes
      wr(`PLLC_ADDR_STATUS, 32'hffffffff);
      rd(`PLLC_ADDR_STATUS, d);
      chk("status after write", 32'hd, d);
      wr(8'h3c, 32'hffffffff);
      rd(8'h3c, d);
      chk("unmapped", 32'h0, d);
      // Timer: fifty ticks over ten cycles, frozen while disabled
      @(posedge mclk);
      t = ref_timer;
      repeat (10) @(posedge mclk);
      chk("timer step", t + 32'd50, ref_timer);
      chk("ref rate", 32'd50, ref_timer - t);
      ce <= 1'b0;
      @(posedge mclk);
      t = ref_timer;
      repeat (4) @(posedge mclk);
      chk("timer frozen", t, ref_timer);
      ce <= 1'b1;
      wrap_up();
   end
endmodule
`default_nettype wire
